/* rtl/slrc_pkg.sv */
// Constants and types shared by the setups/run/cal command block
package slrc_pkg;

   // Clock and tick
   localparam int CLK_MHZ   = 125;
   localparam int T_TICK_US = 1;
   localparam int TICK_CYC  = CLK_MHZ * T_TICK_US;
   localparam int US_PER_MS = 1000;

   // Times as printed
   localparam int T_PAIR_MS     = 100;
   localparam int T_GAP_MS      = 100;
   localparam int T_SELF_RST_MS = 1000;
   localparam int T_ACK_US      = 250;
   localparam int T_CAL_ACK_US  = 450;
   localparam int T_CRC_ACK_US  = 800;
   localparam int T_EE_MS       = 370;

   // Times in 1 us ticks
   localparam int PAIR_US = T_PAIR_MS * US_PER_MS;
   localparam int GAP_US  = T_GAP_MS * US_PER_MS;
   localparam int IDLE_US = T_SELF_RST_MS * US_PER_MS;
   localparam int TMR_W   = 20;

   // Command and response bytes
   localparam logic [7:0] CMD_SETUPS   = 8'h01;
   localparam logic [7:0] CMD_RUN      = 8'h02;
   localparam logic [7:0] CMD_CAL      = 8'h03;
   localparam logic [7:0] CMD_RESET    = 8'h04;
   localparam logic [7:0] ACK_SETUPS   = 8'h53;
   localparam logic [7:0] ACK_RUN      = 8'hFD;
   localparam logic [7:0] ACK_CAL      = 8'hFC;
   localparam logic [7:0] RSP_CRC_BAD  = 8'hF0;
   localparam logic [7:0] RSP_TIMEOUT  = 8'hF1;
   localparam logic [7:0] RSP_EE_FAIL  = 8'hF2;
   localparam logic [7:0] RSP_OK       = 8'hFE;
   localparam logic [7:0] CRC_DUMMY    = 8'hD6;

   // Setups block and CRC
   localparam logic [7:0] SETUP_LEN = 8'h64;
   localparam logic [7:0] CRC_POLY  = 8'h31;
   localparam logic [7:0] CRC_INIT  = 8'h00;

   // Calibration length
   localparam logic [7:0] CAL_CYCLES = 8'h0F;
   localparam logic [7:0] NUM_KEYS   = 8'h0A;
   localparam logic [7:0] CAL_SLOTS  = CAL_CYCLES * NUM_KEYS;

   // Setup source after a load
   typedef enum logic [1:0] {
      SRC_NEW     = 2'h0,
      SRC_EEPROM  = 2'h1,
      SRC_FACTORY = 2'h2
   } slrc_src_t;

   // Main sequencer states
   typedef enum logic [2:0] {
      ST_RUN  = 3'h0,
      ST_LOAD = 3'h1,
      ST_EEWR = 3'h3,
      ST_SUSP = 3'h2,
      ST_CAL  = 3'h6
   } slrc_state_t;

endpackage : slrc_pkg

/* rtl/slrc_ifs.sv */
// Interfaces between the sequencer, its timers and its CRC engine
interface slrc_tmr_if import slrc_pkg::*; ();
   logic             start;
   logic             stop;
   logic [TMR_W-1:0] limit;
   logic             expired;
   modport tmr  (input start, stop, limit, output expired);
   modport user (output start, stop, limit, input expired);
endinterface : slrc_tmr_if

interface slrc_crc_if;
   logic       clr;
   logic       en;
   logic [7:0] data;
   logic [7:0] crc;
   modport eng  (input clr, en, data, output crc);
   modport user (output clr, en, data, input crc);
endinterface : slrc_crc_if

/* rtl/slrc_crc8.sv */
// Bytewise CRC-8 over the setups block data
module slrc_crc8 import slrc_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   slrc_crc_if.eng  c
);

   typedef struct packed {
      logic [7:0] crc;
   } slrc_crc_regs_t;

   slrc_crc_regs_t r;
   slrc_crc_regs_t r_nxt;

   function automatic logic [7:0] slrc_crc_step(input logic [7:0] crc,
                                                input logic [7:0] d);
      logic [7:0] x;
      x = crc ^ d;
      for (int i = 0; i < 8; i++) begin
         x = x[7] ? ((x << 1) ^ CRC_POLY) : (x << 1);
      end
      return x;
   endfunction : slrc_crc_step

   always_comb begin
      r_nxt = r;
      if (c.clr) begin
         r_nxt.crc = CRC_INIT;
      end else if (c.en) begin
         r_nxt.crc = slrc_crc_step(r.crc, c.data);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '{crc: CRC_INIT};
      end else begin
         r <= r_nxt;
      end
   end

   assign c.crc = r.crc;

endmodule : slrc_crc8

/* rtl/slrc_timer.sv */
// Microsecond down-counter with a one-cycle expiry pulse
module slrc_timer import slrc_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   slrc_tmr_if.tmr  t
);

   localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);

   typedef struct packed {
      logic [TMR_W-1:0] cnt;
      logic [6:0]       div;
      logic             run;
      logic             done;
   } slrc_tmr_regs_t;

   slrc_tmr_regs_t r;
   slrc_tmr_regs_t r_nxt;

   always_comb begin
      r_nxt      = r;
      r_nxt.done = 1'b0;
      if (t.start) begin
         r_nxt.cnt = t.limit;
         r_nxt.div = 7'h00;
         r_nxt.run = 1'b1;
      end else if (t.stop) begin
         r_nxt.run = 1'b0;
      end else if (r.run) begin
         if (r.div == TICK_LAST) begin
            r_nxt.div = 7'h00;
            if (r.cnt <= TMR_W'(1)) begin
               r_nxt.run  = 1'b0;
               r_nxt.done = 1'b1;
            end else begin
               r_nxt.cnt = r.cnt - TMR_W'(1);
            end
         end else begin
            r_nxt.div = r.div + 7'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '{cnt: '0, div: 7'h00, run: 1'b0, done: 1'b0};
      end else begin
         r <= r_nxt;
      end
   end

   assign t.expired = r.done;

endmodule : slrc_timer

/* rtl/slrc_cmd_top.sv */
// Setups-load, run and calibrate command sequencer
//
// Functional notes
// RQ1 - Commands 01/02/03 act only when sent twice back to back within 100ms.
// RQ2 - Setups-load double answers 0x53 at once, sent when flow line is high.
// RQ3 - Host resyncs with return-last-command twice, then repeats command.
// RQ4 - After 0x53 bursts stop; host streams block and CRC uninterrupted.
// RQ5 - Host keeps block byte gaps between 10us and 100ms.
// RQ6 - Gap over 100ms sends 0xF1, aborts, reloads EEPROM or factory setups.
// RQ7 - After timeout abort, no 01..04 within 1s causes self-reset.
// RQ8 - Host watches for 0xF1 during block and restarts the load.
// RQ9 - In SPI mode host shifts nulls to fetch every response.
// RQ10 - Without EEPROM, CRC checked; F0 bad, FE good; factory on failure.
// RQ11 - With EEPROM and good CRC, block written; F2 on failure, FE success.
// RQ12 - Host resets device if no answer 370ms after block.
// RQ13 - EEPROM written only after clean block with good or dummy CRC.
// RQ14 - After load suspend; no 01..04 in 1s self-resets then calibrates.
// RQ15 - F2 runs factory defaults; F0 or F1 runs stored EEPROM setups.
// RQ16 - Block CRC covers block data only, never the command byte.
// RQ17 - CRC byte 0xD6 always accepted; true CRC still stored.
// RQ18 - Host: threshold edits need calibrate, spread-spectrum edits a reset.
// RQ19 - Run double resumes sensing without recalibration, answers 0xFD.
// RQ20 - Calibrate double answers 0xFC, then calibrates all keys together.
// RQ21 - Calibration lasts 150 timeslots always; also entered after reset. Here a setups double during calibration ends it early.
// RQ22 - Host polls highest enabled key status for calibration progress.
// RQ23 - Host waits for flow line high; 10us grace at a late pull-down.
// RQ24 - Flow line held low during acquisition bursts.
// RQ25 - Fixed block length marks the trailing CRC byte.
module slrc_cmd_top import slrc_pkg::*; #(
   parameter int P_PAIR_US = PAIR_US,
   parameter int P_GAP_US  = GAP_US,
   parameter int P_IDLE_US = IDLE_US
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       rx_valid,
   input  wire logic [7:0] rx_data,
   input  wire logic       tx_ready,
   output logic            tx_valid,
   output logic [7:0]      tx_data,
   input  wire logic       flow_ready_line_in,
   output logic            flow_ready_line_out,
   output logic            flow_ready_line_oe,
   input  wire logic       burst_active,
   input  wire logic       slot_tick,
   input  wire logic       eeprom_present_strap,
   input  wire logic       eeprom_valid,
   input  wire logic       ee_done,
   input  wire logic       ee_ok,
   output logic            ee_write_start,
   output logic [7:0]      ee_crc,
   output logic            setup_byte_valid,
   output logic [7:0]      setup_byte_data,
   output logic            setup_apply,
   output slrc_src_t       setup_src,
   output logic            acq_halt,
   output logic            calibrating,
   output logic            cal_start,
   output logic            self_reset
);

   typedef struct packed {
      slrc_state_t st;
      logic        pend;
      logic [7:0]  pend_cmd;
      logic [7:0]  cnt;
      logic [7:0]  slots;
      logic [7:0]  rsp;
      logic        rsp_pend;
      logic        tx_valid;
      logic [7:0]  tx_data;
      logic        flow_oe;
      logic        acq_halt;
      logic        calibrating;
      logic        cal_start;
      logic        self_reset;
      logic        ee_start;
      logic [7:0]  ee_crc;
      logic        apply;
      slrc_src_t   src;
      logic        sb_valid;
      logic [7:0]  sb_data;
      logic [1:0]  strap_sync;
      logic [1:0]  fr_sync;
   } slrc_regs_t;

   slrc_regs_t r;
   slrc_regs_t r_nxt;

   slrc_tmr_if tp ();
   slrc_tmr_if tl ();
   slrc_crc_if ci ();

   logic      ee_present;
   logic      pairing;
   logic      dbl_c;
   logic      crc_byte;
   logic      crc_good;
   slrc_src_t reload_src;

   slrc_timer u_pair_tmr (
      .clk (clk),
      .rst (rst),
      .t   (tp.tmr)
   );

   slrc_timer u_long_tmr (
      .clk (clk),
      .rst (rst),
      .t   (tl.tmr)
   );

   slrc_crc8 u_crc (
      .clk (clk),
      .rst (rst),
      .c   (ci.eng)
   );

   // Strap tied high means no EEPROM
   assign ee_present = ~r.strap_sync[1];
   assign pairing    = (r.st != ST_LOAD) && (r.st != ST_EEWR);
   assign dbl_c      = pairing && rx_valid && r.pend &&
                       (rx_data == r.pend_cmd) && !tp.expired &&
                       !(r.st == ST_SUSP && tl.expired); // [RQ1]
   assign crc_byte   = (r.st == ST_LOAD) && rx_valid &&
                       (r.cnt == SETUP_LEN); // [RQ25]
   assign crc_good   = (rx_data == ci.crc) || (rx_data == CRC_DUMMY); // [RQ17]
   assign reload_src = (ee_present && eeprom_valid) ? SRC_EEPROM
                                                    : SRC_FACTORY; // [RQ15]

   always_comb begin
      r_nxt             = r;
      r_nxt.cal_start   = 1'b0;
      r_nxt.self_reset  = 1'b0;
      r_nxt.ee_start    = 1'b0;
      r_nxt.apply       = 1'b0;
      r_nxt.sb_valid    = 1'b0;
      r_nxt.strap_sync  = {r.strap_sync[0], eeprom_present_strap};
      r_nxt.fr_sync     = {r.fr_sync[0], flow_ready_line_in};
      tp.start          = 1'b0;
      tp.stop           = 1'b0;
      tp.limit          = TMR_W'(P_PAIR_US);
      tl.start          = 1'b0;
      tl.stop           = 1'b0;
      tl.limit          = TMR_W'(P_IDLE_US);
      ci.clr            = 1'b0;
      ci.en             = 1'b0;
      ci.data           = rx_data;

      // Pair window lapsed: first byte forgotten, no reset
      if (tp.expired && pairing) begin
         r_nxt.pend = 1'b0; // [RQ1]
      end

      // Response hand-off, waits for the flow line high
      if (r.tx_valid && tx_ready) begin
         r_nxt.tx_valid = 1'b0;
      end
      if (r.rsp_pend && !r.tx_valid && r.fr_sync[1]) begin
         r_nxt.tx_valid = 1'b1; // [RQ2]
         r_nxt.tx_data  = r.rsp;
         r_nxt.rsp_pend = 1'b0;
      end

      // Line low during bursts and while the EEPROM is busy
      r_nxt.flow_oe = burst_active || (r.st == ST_EEWR); // [RQ24]

      unique case (r.st)
         ST_LOAD: begin
            if (rx_valid && !crc_byte) begin
               tp.start       = 1'b1;
               tp.limit       = TMR_W'(P_GAP_US);
               ci.en          = 1'b1; // [RQ16]
               r_nxt.sb_valid = 1'b1;
               r_nxt.sb_data  = rx_data;
               r_nxt.cnt      = r.cnt + 8'h01;
            end else if (crc_byte) begin
               tp.stop      = 1'b1;
               r_nxt.ee_crc = ci.crc; // [RQ17]
               if (!crc_good) begin
                  r_nxt.rsp      = RSP_CRC_BAD; // [RQ10]
                  r_nxt.rsp_pend = 1'b1;
                  r_nxt.src      = reload_src; // [RQ15]
                  r_nxt.apply    = 1'b1;
                  r_nxt.st       = ST_SUSP;
                  tl.start       = 1'b1; // [RQ14]
               end else if (!ee_present) begin
                  r_nxt.rsp      = RSP_OK; // [RQ10]
                  r_nxt.rsp_pend = 1'b1;
                  r_nxt.src      = SRC_NEW;
                  r_nxt.apply    = 1'b1;
                  r_nxt.st       = ST_SUSP;
                  tl.start       = 1'b1; // [RQ14]
               end else begin
                  r_nxt.ee_start = 1'b1; // [RQ13]
                  r_nxt.st       = ST_EEWR;
               end
            end else if (tp.expired) begin
               r_nxt.rsp      = RSP_TIMEOUT; // [RQ6]
               r_nxt.rsp_pend = 1'b1;
               r_nxt.src      = reload_src; // [RQ6]
               r_nxt.apply    = 1'b1;
               r_nxt.st       = ST_SUSP;
               tl.start       = 1'b1; // [RQ7]
            end
         end
         ST_EEWR: begin
            if (ee_done) begin
               r_nxt.rsp      = ee_ok ? RSP_OK : RSP_EE_FAIL; // [RQ11]
               r_nxt.rsp_pend = 1'b1;
               r_nxt.src      = ee_ok ? SRC_NEW : SRC_FACTORY; // [RQ15]
               r_nxt.apply    = 1'b1;
               r_nxt.st       = ST_SUSP;
               tl.start       = 1'b1; // [RQ14]
            end
         end
         ST_CAL: begin
            if (slot_tick) begin
               if (r.slots == CAL_SLOTS - 8'h01) begin
                  r_nxt.calibrating = 1'b0; // [RQ21]
                  r_nxt.st          = ST_RUN;
               end else begin
                  r_nxt.slots = r.slots + 8'h01;
               end
            end
         end
         ST_SUSP: begin
            if (tl.expired) begin
               r_nxt.self_reset  = 1'b1; // [RQ14]
               r_nxt.st          = ST_CAL;
               r_nxt.calibrating = 1'b1;
               r_nxt.cal_start   = 1'b1;
               r_nxt.slots       = 8'h00;
               r_nxt.acq_halt    = 1'b0;
               r_nxt.pend        = 1'b0;
            end
         end
         ST_RUN: begin
         end
      endcase

      // Any of 01..04 cancels the self-reset countdown
      if (pairing && rx_valid && (rx_data >= CMD_SETUPS) &&
          (rx_data <= CMD_RESET)) begin
         tl.stop = 1'b1; // [RQ7]
      end

      // Double-command detection
      if (pairing && rx_valid && !(r.st == ST_SUSP && tl.expired)) begin
         if (dbl_c) begin
            r_nxt.pend = 1'b0;
            tp.stop    = 1'b1;
            if (r.pend_cmd == CMD_SETUPS) begin
               r_nxt.rsp      = ACK_SETUPS; // [RQ2]
               r_nxt.rsp_pend = 1'b1;
               r_nxt.st       = ST_LOAD;
               r_nxt.acq_halt = 1'b1; // [RQ4]
               r_nxt.calibrating = 1'b0;
               r_nxt.cnt      = 8'h00;
               ci.clr         = 1'b1; // [RQ16]
               tp.stop        = 1'b0;
               tp.start       = 1'b1;
               tp.limit       = TMR_W'(P_GAP_US); // [RQ6]
            end else if (r.pend_cmd == CMD_RUN) begin
               r_nxt.rsp      = ACK_RUN; // [RQ19]
               r_nxt.rsp_pend = 1'b1;
               r_nxt.acq_halt = 1'b0;
               if (r.st != ST_CAL) begin
                  r_nxt.st = ST_RUN;
               end
            end else begin
               r_nxt.rsp         = ACK_CAL; // [RQ20]
               r_nxt.rsp_pend    = 1'b1;
               r_nxt.st          = ST_CAL;
               r_nxt.calibrating = 1'b1;
               r_nxt.cal_start   = 1'b1;
               r_nxt.slots       = 8'h00;
               r_nxt.acq_halt    = 1'b0;
            end
         end else if ((rx_data >= CMD_SETUPS) && (rx_data <= CMD_CAL)) begin
            r_nxt.pend     = 1'b1; // [RQ1]
            r_nxt.pend_cmd = rx_data;
            tp.start       = 1'b1;
         end else begin
            r_nxt.pend = 1'b0; // [RQ1]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '{st: ST_CAL, calibrating: 1'b1, src: SRC_NEW,
                strap_sync: 2'h3, default: '0}; // [RQ21]
      end else begin
         r <= r_nxt;
      end
   end

   assign tx_valid            = r.tx_valid;
   assign tx_data             = r.tx_data;
   assign flow_ready_line_out = 1'b0;
   assign flow_ready_line_oe  = r.flow_oe;
   assign ee_write_start      = r.ee_start;
   assign ee_crc              = r.ee_crc;
   assign setup_byte_valid    = r.sb_valid;
   assign setup_byte_data     = r.sb_data;
   assign setup_apply         = r.apply;
   assign setup_src           = r.src;
   assign acq_halt            = r.acq_halt;
   assign calibrating         = r.calibrating;
   assign cal_start           = r.cal_start;
   assign self_reset          = r.self_reset;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_dbl(logic [7:0] cmd);
      dbl_c && (rx_data == cmd);
   endsequence

   sequence s_block_end;
      crc_byte;
   endsequence

   AST_SETUP_ACK: assert property ( // [RQ2]
      s_dbl(CMD_SETUPS) |=> r.rsp_pend && r.rsp == ACK_SETUPS &&
                            r.st == ST_LOAD && r.acq_halt && !r.calibrating)
      else $error("setups double not acknowledged");

   AST_TX_GO: assert property ( // [RQ2]
      r.rsp_pend && !r.tx_valid && r.fr_sync[1] |=>
      r.tx_valid && tx_data == $past(r.rsp))
      else $error("pending response not offered");

   AST_SINGLE_IDLE: assert property ( // [RQ1]
      rx_valid && !dbl_c && r.st == ST_RUN && !r.rsp_pend |=> !r.rsp_pend)
      else $error("single command byte produced a response");

   AST_HALT_LOAD: assert property ( // [RQ4]
      r.st == ST_LOAD |-> r.acq_halt)
      else $error("acquisition not halted during block load");

   AST_GAP_ABORT: assert property ( // [RQ6]
      r.st == ST_LOAD && !rx_valid && tp.expired |=>
      r.rsp == RSP_TIMEOUT && r.rsp_pend && r.st == ST_SUSP && r.apply)
      else $error("gap timeout not answered with timeout code");

   AST_NOEE_RESULT: assert property ( // [RQ10]
      s_block_end and !ee_present |=> r.rsp_pend && r.st == ST_SUSP &&
      (r.rsp == RSP_OK || r.rsp == RSP_CRC_BAD) && r.apply)
      else $error("no-EEPROM block end without result");

   AST_EE_ONLY_GOOD: assert property ( // [RQ13]
      $rose(r.ee_start) |-> $past(crc_byte) && $past(crc_good))
      else $error("EEPROM write without a good block");

   AST_DUMMY_OK: assert property ( // [RQ17]
      s_block_end and rx_data == CRC_DUMMY |=>
      (r.rsp == RSP_OK && r.rsp_pend) || r.ee_start)
      else $error("dummy CRC refused");

   AST_EE_FAIL: assert property ( // [RQ15]
      r.st == ST_EEWR && ee_done && !ee_ok |=>
      r.rsp == RSP_EE_FAIL && r.src == SRC_FACTORY && r.apply)
      else $error("EEPROM failure not reported");

   AST_SELF_RESET: assert property ( // [RQ14]
      r.st == ST_SUSP && tl.expired |=>
      r.self_reset && r.st == ST_CAL ##1 !r.self_reset && r.calibrating)
      else $error("suspend timeout did not self-reset");

   AST_RUN_ACK: assert property ( // [RQ19]
      s_dbl(CMD_RUN) |=> r.rsp == ACK_RUN && !r.acq_halt && !r.cal_start)
      else $error("run double not acknowledged");

   AST_CAL_ACK: assert property ( // [RQ20]
      s_dbl(CMD_CAL) |=> r.rsp == ACK_CAL && r.cal_start ##1 !r.cal_start)
      else $error("calibrate double not acknowledged");

   AST_FLOW_BURST: assert property ( // [RQ24]
      burst_active |=> flow_ready_line_oe)
      else $error("flow line released during burst");

endmodule : slrc_cmd_top

/* verif/slrc_host_model.sv */
// Host-side model: accepts responses and shares the flow line
module slrc_host_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       busy,
   input  wire logic       flow_ready_line_oe,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   output logic            flow_ready_line_in,
   output logic            got,
   output logic [7:0]      got_data
);
   timeunit 1ns;
   timeprecision 1ps;

   // Wired-AND with pull-up: low while either side pulls
   assign flow_ready_line_in = ~(flow_ready_line_oe | busy);

   // Response byte taken at the edge where ready meets valid
   always @(posedge clk) begin
      tx_ready <= ~busy & ~rst;
      got      <= tx_valid & tx_ready & ~rst;
      if (tx_valid & tx_ready)
         got_data <= tx_data;
   end
endmodule : slrc_host_model

/* verif/setups_load_run_cal_commands_bench.sv */
// Self-checking bench for the setups, run and calibrate commands
module setups_load_run_cal_commands_bench import slrc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PP = 50;
   localparam int PG = 50;
   localparam int PI = 200;
   logic       clk, rst, rx_valid, tx_ready, tx_valid, busy, got;
   logic       flow_ready_line_in, flow_ready_line_oe, burst_active;
   logic       slot_tick, eeprom_present_strap, eeprom_valid, ee_done;
   logic       ee_ok, ee_write_start, setup_byte_valid, setup_apply;
   logic       acq_halt, calibrating, cal_start, self_reset;
   logic [7:0] rx_data, tx_data, ee_crc, setup_byte_data, got_data;
   logic [7:0] rsp, cexp;
   logic [7:0] blk [0:99];
   slrc_src_t  setup_src, last_src;
   int         seed, fail_count, checks, n_data, n_eew, n_srst, n_cal;
   int         n_rsp, r0, e0;

   slrc_cmd_top #(.P_PAIR_US(PP), .P_GAP_US(PG), .P_IDLE_US(PI)) dut (
      .clk, .rst, .rx_valid, .rx_data, .tx_ready, .tx_valid, .tx_data,
      .flow_ready_line_in, .flow_ready_line_out(), .flow_ready_line_oe,
      .burst_active, .slot_tick, .eeprom_present_strap, .eeprom_valid,
      .ee_done, .ee_ok, .ee_write_start, .ee_crc, .setup_byte_valid,
      .setup_byte_data, .setup_apply, .setup_src, .acq_halt, .calibrating,
      .cal_start, .self_reset);

   slrc_host_model host (.clk, .rst, .busy, .flow_ready_line_oe, .tx_valid,
      .tx_data, .tx_ready, .flow_ready_line_in, .got, .got_data);

   always #4 clk = ~clk;

   // Random bursts and host stalls
   always @(posedge clk) begin
      burst_active <= ($random(seed) & 15) == 0;
      busy         <= ($random(seed) & 15) == 0;
   end

   // Event counters, sampled mid-cycle
   always @(negedge clk) begin
      if (setup_byte_valid === 1'h1) begin
         check("block byte", setup_byte_data, blk[n_data]);
         n_data++;
      end
      if (got === 1'h1) begin
         rsp = got_data;
         n_rsp++;
      end
      n_eew  += int'(ee_write_start === 1'h1);
      n_srst += int'(self_reset === 1'h1);
      n_cal  += int'(cal_start === 1'h1);
      if (setup_apply === 1'h1)
         last_src = setup_src;
   end

   task automatic check(input string nm, input logic [7:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   task automatic await(input string nm, ref int cnt, input int base, lim);
      int n;
      n = 0;
      while (cnt == base) begin
         @(posedge clk);
         n++;
         if (n > lim) begin
            $display("[FAIL] %s expected event seen none", nm);
            fail_count++;
            complete_run();
         end
      end
   endtask : await

   task automatic send(input logic [7:0] b);
      int n;
      n = 0;
      while (flow_ready_line_in !== 1'h1) begin
         @(posedge clk);
         n++;
         if (n > 5000)
            await("flow", n, n, 0);
      end
      rx_valid <= 1'h1;
      rx_data  <= b;
      @(posedge clk);
      rx_valid <= 1'h0;
      repeat (2) @(posedge clk);
   endtask : send

   task automatic cmd2(input logic [7:0] b);
      r0 = n_rsp;
      send(b);
      send(b);
   endtask : cmd2

   task automatic rsp_is(input logic [7:0] e, input int cyc);
      await("reply", n_rsp, r0, cyc);
      check("reply", rsp, e);
      r0 = n_rsp;
   endtask : rsp_is

   task automatic quiet(input int cyc);
      repeat (cyc) @(posedge clk);
      check("no reply", 8'(n_rsp - r0), 8'h00);
   endtask : quiet

   task automatic slot();
      slot_tick <= 1'h1;
      @(posedge clk);
      slot_tick <= 1'h0;
      @(posedge clk);
   endtask : slot

   function automatic logic [7:0] crc_next(input logic [7:0] c, d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++)
         r = r[7] ? {r[6:0], 1'h0} ^ CRC_POLY : {r[6:0], 1'h0};
      return r;
   endfunction : crc_next

   // Mode 0 good CRC, 1 dummy CRC, 2 bad CRC
   task automatic load(input int mode);
      logic [7:0] c;
      c = CRC_INIT;
      cmd2(CMD_SETUPS);
      rsp_is(ACK_SETUPS, T_ACK_US * TICK_CYC);
      check("halt", acq_halt, 8'h01);
      check("cal", calibrating, 8'h00);
      n_data = 0;
      for (int i = 0; i < 100; i++) begin
         blk[i] = 8'($random(seed));
         c = crc_next(c, blk[i]);
         send(blk[i]);
      end
      cexp = c;
      r0 = n_rsp;
      e0 = n_eew;
      if (mode == 2)
         c = ~c ^ {7'h00, ~c == CRC_DUMMY};
      send(mode == 1 ? CRC_DUMMY : c);
      check("block count", 8'(n_data), SETUP_LEN);
   endtask : load

   task automatic ee_end(input logic ok);
      await("ee start", n_eew, e0, 2000);
      check("ee crc", ee_crc, cexp);
      repeat (20) @(posedge clk);
      ee_done <= 1'h1;
      ee_ok   <= ok;
      @(posedge clk);
      ee_done <= 1'h0;
   endtask : ee_end

   initial begin
      int k;
      seed = 32'hD058;
      clk = 1'h0;
      rst = 1'h1;
      rx_valid = 1'h0;
      rx_data = 8'h00;
      slot_tick = 1'h0;
      eeprom_present_strap = 1'h1;
      eeprom_valid = 1'h1;
      ee_done = 1'h0;
      ee_ok = 1'h0;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      check("cal", calibrating, 8'h01);
      repeat (int'(CAL_SLOTS) - 1) slot();
      check("cal", calibrating, 8'h01);
      slot();
      check("cal", calibrating, 8'h00);
      $display("calibration test done");
      send(CMD_RUN);
      send(CMD_CAL);
      send(CMD_RUN);
      send(8'h00);
      send(CMD_RUN);
      quiet(PP * TICK_CYC + 500);
      send(8'hC7);
      send(8'hC7);
      send(CMD_RUN);
      quiet(200);
      send(CMD_RUN);
      rsp_is(ACK_RUN, T_ACK_US * TICK_CYC);
      check("halt", acq_halt, 8'h00);
      check("cal", calibrating, 8'h00);
      k = n_cal;
      cmd2(CMD_CAL);
      rsp_is(ACK_CAL, T_CAL_ACK_US * TICK_CYC);
      check("cal start", 8'(n_cal - k), 8'h01);
      check("cal", calibrating, 8'h01);
      $display("pair tests done");
      load(0);
      rsp_is(RSP_OK, T_CRC_ACK_US * TICK_CYC);
      check("src", last_src, SRC_NEW);
      load(1);
      rsp_is(RSP_OK, T_CRC_ACK_US * TICK_CYC);
      load(2);
      rsp_is(RSP_CRC_BAD, T_CRC_ACK_US * TICK_CYC);
      check("src", last_src, SRC_FACTORY);
      check("ee writes", 8'(n_eew), 8'h00);
      eeprom_present_strap <= 1'h0;
      load(2);
      rsp_is(RSP_CRC_BAD, T_CRC_ACK_US * TICK_CYC);
      check("src", last_src, SRC_EEPROM);
      check("ee writes", 8'(n_eew), 8'h00);
      load(1);
      ee_end(1'h1);
      rsp_is(RSP_OK, T_CRC_ACK_US * TICK_CYC);
      check("src", last_src, SRC_NEW);
      cmd2(CMD_CAL);
      rsp_is(ACK_CAL, T_CAL_ACK_US * TICK_CYC);
      load(0);
      ee_end(1'h0);
      rsp_is(RSP_EE_FAIL, T_CRC_ACK_US * TICK_CYC);
      check("src", last_src, SRC_FACTORY);
      k = n_srst;
      send(CMD_RESET);
      repeat (PI * TICK_CYC + 1000) @(posedge clk);
      check("self reset", 8'(n_srst - k), 8'h00);
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      check("cal", calibrating, 8'h01);
      check("halt", acq_halt, 8'h00);
      $display("load tests done");
      cmd2(CMD_SETUPS);
      rsp_is(ACK_SETUPS, T_ACK_US * TICK_CYC);
      n_data = 0;
      blk[0] = 8'h5A;
      send(8'h5A);
      rsp_is(RSP_TIMEOUT, PG * TICK_CYC + 1000);
      check("src", last_src, SRC_EEPROM);
      k = n_cal;
      await("self reset", n_srst, n_srst, PI * TICK_CYC + 1000);
      repeat (3) @(posedge clk);
      check("cal start", 8'(n_cal - k), 8'h01);
      check("cal", calibrating, 8'h01);
      check("halt", acq_halt, 8'h00);
      $display("timeout test done");
      complete_run();
   end
endmodule : setups_load_run_cal_commands_bench
